//--- design/gpio_port_with_pin_steering.sv
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "gpio_port_consts.svh"
// Overview of operation
// - Latch writes equal pin-data writes when the byte enable is set.
// - Latch reads latch; pin data reads pins.
// - Analog select disables digital input path.
// - Analog pins read zero digitally.
// - Direction one inputs, zero drives latch.
// - First port has six bits, five bidirectional.
// - Bit three input-only, direction reads one.
// - Port writes merge current pin levels.
// - Analog select leaves digital output alone.
// - Analog select bits reset set.
// - Enabled peripheral output overrides latch.
// - Highest priority enabled function wins.
// - Bit0 programming data, bit4 clock output.
// - Outputs keep priority in analog mode.
// - Steering never alters direction registers.
// - Bit7 places UART receive/data.
// - Bit6 places SPI data output.
// - Bit5 places SPI slave select.
// - Bit4 places I2C/SPI data input.
// - Bit2 places UART transmit; bit3 zero.
// - Bit1 swaps converter B guards.
// - Bit0 swaps converter A guards.
module gpio_port_with_pin_steering
  import gpio_port_pkg::*;
#(
  parameter bit VARIANT_14 = 1'b1
) (
  // Clock and synchronous reset
  input wire logic clk,
  input wire logic rstn,
  // Register bus: write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // Register bus: write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Register bus: write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Register bus: read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // Register bus: read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // First port pins, levels in and drive out
  input wire logic [5:0] port_a_pin_in,
  output logic [5:0] port_a_pin_out,
  output logic [5:0] port_a_pin_oe,
  // Other ports' pins seen by the steered inputs
  input wire logic [7:0] port_c_pin_in,
  input wire logic port_b4_pin_in,
  // Peripheral side
  input wire periph_out_t periph_out,
  output periph_in_t periph_in,
  output steer_out_t steer_out
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  // One packed struct holds every register of the block
  // Reset and next-state copy then cover all of it at once
  state_t q; // Registered state
  state_t d; // Next state

  // Implemented steering bits for this variant
  // Unimplemented bits masked on write, so they read back 0
  // 14-pin keeps all but bit 3; 20-pin keeps only bits 5, 4, 1 and 0 (slave select, data input and swap bits)
  localparam logic [7:0] STEER_MASK = VARIANT_14 ? `STEER_MASK_14 : `STEER_MASK_20;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Word address: low two byte-address bits carry no meaning
  function automatic logic [7:0] word_addr(input logic [7:0] a);
    word_addr = a & 8'hFC;
  endfunction

  // Address decode: known register offset
  // Anything else answers with an error and changes nothing
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == `OFS_PIN_DATA) || (a == `OFS_DIRECTION) || (a == `OFS_LATCH) ||
              (a == `OFS_ANALOG_SEL) || (a == `OFS_STEERING);
  endfunction

  // Digital pin readback, analog pins forced low
  // Input-only pin has no analog select, always reads its level
  function automatic logic [5:0] pin_read(input state_t s);
    pin_read = s.pa_sync2 & ~(s.analog_select_reg & `ANALOG_SEL_MASK);
  endfunction

  // Register read value
  // Unimplemented upper bits of every register read 0
  function automatic logic [7:0] reg_read(input state_t s, input logic [7:0] a);
    reg_read = 8'h00;
    case (a)
      `OFS_PIN_DATA: reg_read = {2'b00, pin_read(s)};
      `OFS_DIRECTION: reg_read = {2'b00, s.direction_reg};
      `OFS_LATCH: reg_read = {2'b00, s.output_latch_reg};
      `OFS_ANALOG_SEL: reg_read = {2'b00, s.analog_select_reg};
      `OFS_STEERING: reg_read = s.alternate_pin_steering;
      default: reg_read = 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  // Bus handshakes, register writes, pin drive and steering in one pass
  // Every pin and steering output field is rebuilt from defaults each cycle
  always_comb begin
    // Scratch values, all set before use
    logic [5:0] rd_pins;
    logic [7:0] st;
    logic [5:0] lat;
    logic [5:0] pout;
    logic [5:0] poe;
    steer_out_t so;
    // Defaults: every register holds, nothing extra driven
    rd_pins = pin_read(q);
    st = q.alternate_pin_steering;
    lat = 6'h00;
    pout = 6'h00;
    poe = 6'h00;
    so = '0;
    d = q;

    // Pin synchronisers
    // Pins are asynchronous; only the second stage feeds logic
    d.pa_sync1 = port_a_pin_in;
    d.pa_sync2 = q.pa_sync1;
    d.pc_sync1 = port_c_pin_in;
    d.pc_sync2 = q.pc_sync1;
    d.pb4_sync1 = port_b4_pin_in;
    d.pb4_sync2 = q.pb4_sync1;

    // Write address channel
    // Address held until the data half arrives
    if (s_axi_awvalid && q.awready) begin
      d.aw_have = 1'b1;
      d.aw_addr = word_addr(s_axi_awaddr);
    end

    // Write data channel
    // Only the low byte lane carries register bits
    // Its byte enable decides whether the write lands
    if (s_axi_wvalid && q.wready) begin
      d.w_have = 1'b1;
      d.w_data = s_axi_wdata[7:0];
      d.w_strb0 = s_axi_wstrb[0];
    end

    // Perform write once both halves are held
    // Both readies are low here, so no new half arrives meanwhile
    if (q.aw_have && q.w_have) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = addr_ok(q.aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
      case (q.aw_addr)
        // Pin data write lands in the latch, unwritten lane takes pin levels
        // Peripheral-driven pins read back their level, not the latch
        `OFS_PIN_DATA: begin
          d.output_latch_reg = q.w_strb0 ? q.w_data[5:0] : rd_pins;
        end
        // Latch write, same effect as a pin data write when the byte enable is set
        `OFS_LATCH: begin
          if (q.w_strb0) begin
            d.output_latch_reg = q.w_data[5:0];
          end
        end
        // Direction write; input-only pin stays an input
        `OFS_DIRECTION: begin
          if (q.w_strb0) begin
            d.direction_reg = q.w_data[5:0];
            d.direction_reg[`INPUT_ONLY_BIT] = 1'b1;
          end
        end
        // Analog select write; unimplemented bits stay clear
        `OFS_ANALOG_SEL: begin
          if (q.w_strb0) begin
            d.analog_select_reg = q.w_data[5:0] & `ANALOG_SEL_MASK;
          end
        end
        // Steering write; bits absent on this variant stay clear
        `OFS_STEERING: begin
          if (q.w_strb0) begin
            d.alternate_pin_steering = q.w_data & STEER_MASK;
          end
        end
        // Unmapped offset: error response, nothing changes
        default: begin
          d.bresp = `RESP_SLVERR;
        end
      endcase
      // No latch cell behind the input-only pin, reads 0
      d.output_latch_reg[`INPUT_ONLY_BIT] = 1'b0;
    end

    // Write response handshake
    // Response stands until the master takes it
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    // Ready again once the held half is used and the response taken
    d.awready = ~d.aw_have & ~d.bvalid & ~(q.aw_have & q.w_have);
    d.wready = ~d.w_have & ~d.bvalid & ~(q.aw_have & q.w_have);

    // Read channel: answer one cycle after address accepted
    // Data captured when the address is taken, then held
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rdata = {24'h00_0000, reg_read(q, word_addr(s_axi_araddr))};
      d.rresp = addr_ok(word_addr(s_axi_araddr)) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    // One read outstanding at a time
    d.arready = ~d.rvalid;

    // First port: latch drives where direction is clear
    // Analog select plays no part in the output path
    lat = q.output_latch_reg;
    pout = lat;
    poe = ~q.direction_reg;

    // Bit 0: programming data above latch
    // Enable overrides the direction bit as well as the latch
    if (periph_out.prog_data_oe) begin
      pout[0] = periph_out.prog_data;
      poe[0] = 1'b1;
    end

    // Bit 4: clock output, then steered serial outputs, then latch
    // Serial outputs reach this pin only when steered here
    if (periph_out.clock_output_en) begin
      pout[4] = periph_out.clock_output;
      poe[4] = 1'b1;
    end else if (periph_out.spi_sdo_en && st[`STEER_SDO_BIT]) begin
      pout[4] = periph_out.spi_sdo;
      poe[4] = 1'b1;
    end else if (periph_out.uart_dt_oe && st[`STEER_RX_BIT]) begin
      pout[4] = periph_out.uart_dt_out;
      poe[4] = 1'b1;
    end

    // Input-only pin never drives
    // Applied last so no peripheral can turn its driver on
    poe[`INPUT_ONLY_BIT] = 1'b0;
    pout[`INPUT_ONLY_BIT] = 1'b0;

    // Guard outputs on the third port
    // Lowest priority on every third-port pin it shares
    // Swap bits pick which converter lands on which pin
    if (periph_out.guard_en) begin
      so.port_c_oe[2] = 1'b1;
      so.port_c_oe[3] = 1'b1;
      so.port_c_oe[4] = 1'b1;
      so.port_c_oe[5] = 1'b1;
      so.port_c_val[2] = st[`STEER_GRDB_BIT] ? periph_out.conv2_guard_b
                                            : periph_out.conv1_guard_b;
      so.port_c_val[3] = st[`STEER_GRDB_BIT] ? periph_out.conv1_guard_b
                                            : periph_out.conv2_guard_b;
      so.port_c_val[4] = st[`STEER_GRDA_BIT] ? periph_out.conv2_guard_a
                                            : periph_out.conv1_guard_a;
      so.port_c_val[5] = st[`STEER_GRDA_BIT] ? periph_out.conv1_guard_a
                                            : periph_out.conv2_guard_a;
    end

    // Serial outputs take precedence over guards on shared pins
    // Later assignments here override the guard drive above
    if (periph_out.spi_sdo_en && !st[`STEER_SDO_BIT]) begin
      so.port_c_oe[2] = 1'b1;
      so.port_c_val[2] = periph_out.spi_sdo;
    end
    // Transmit/clock on one of two third-port pins
    if (periph_out.uart_tx_oe) begin
      if (st[`STEER_TX_BIT]) begin
        so.port_c_oe[3] = 1'b1;
        so.port_c_val[3] = periph_out.uart_tx_out;
      end else begin
        so.port_c_oe[4] = 1'b1;
        so.port_c_val[4] = periph_out.uart_tx_out;
      end
    end
    // Receive/data drives its default pin unless steered away
    if (periph_out.uart_dt_oe && !st[`STEER_RX_BIT]) begin
      so.port_c_oe[5] = 1'b1;
      so.port_c_val[5] = periph_out.uart_dt_out;
    end

    // I2C data output never reaches the input-only pin
    // With the select bit set only the input side is steered there
    // Default target depends on the package variant
    if (periph_out.sda_oe && !st[`STEER_SD_BIT]) begin
      if (VARIANT_14) begin
        so.port_c_oe[1] = 1'b1;
        so.port_c_val[1] = periph_out.sda_out;
      end else begin
        so.port_b4_oe = 1'b1;
        so.port_b4_val = periph_out.sda_out;
      end
    end

    // Steered inputs toward peripherals
    // Port A sources pass the analog gating, like a register read
    d.pin_to_periph.uart_receive_data = st[`STEER_RX_BIT] ? rd_pins[4] : q.pc_sync2[5];
    // Slave select from the first port or a third-port pin
    if (st[`STEER_SS_BIT]) begin
      d.pin_to_periph.slave_select = VARIANT_14 ? q.pc_sync2[3] : q.pc_sync2[6];
    end else begin
      d.pin_to_periph.slave_select = rd_pins[`INPUT_ONLY_BIT];
    end
    // Serial data input from the first port or its default pin
    if (st[`STEER_SD_BIT]) begin
      d.pin_to_periph.serial_data_in = rd_pins[`INPUT_ONLY_BIT];
    end else begin
      d.pin_to_periph.serial_data_in = VARIANT_14 ? q.pc_sync2[1] : q.pb4_sync2;
    end

    // Drive values registered so the pins come from flip-flops
    d.pin_out = pout;
    d.pin_oe = poe;
    d.steer_out = so;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register with synchronous reset
  // Reset loads register defaults and opens every bus channel
  // Fields not named below reset to zero
  always_ff @(posedge clk) begin
    if (!rstn) begin
      q <= '0;
      q.direction_reg <= `RST_DIRECTION;
      q.output_latch_reg <= `RST_LATCH;
      q.analog_select_reg <= `RST_ANALOG_SEL;
      q.alternate_pin_steering <= `RST_STEERING;
      // Channels open straight out of reset
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from state
  // Bus channels
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  // Pins, steered inputs and overrides
  assign port_a_pin_out = q.pin_out;
  assign port_a_pin_oe = q.pin_oe;
  assign periph_in = q.pin_to_periph;
  assign steer_out = q.steer_out;

endmodule

//--- dv/gpio_port_sva.sv
`timescale 1ns/1ps
`include "gpio_port_consts.svh"
////////////////////////////////////////
// Port checker, sees top ports only
module gpio_port_sva
  import gpio_port_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [5:0] port_a_pin_out,
  input wire logic [5:0] port_a_pin_oe,
  input wire periph_out_t periph_out
);
  // One clock, quiet during reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_bit3_never_drives: assert property (!port_a_pin_oe[3])
    else $error("input-only pin driven");
  a_prog_data_wins: assert property ($past(rstn) && $past(periph_out.prog_data_oe) |->
    port_a_pin_oe[0] && port_a_pin_out[0] == $past(periph_out.prog_data))
    else $error("pin 0 not given to programming data");
  a_clock_output_wins: assert property ($past(rstn) && $past(periph_out.clock_output_en) |->
    port_a_pin_oe[4] && port_a_pin_out[4] == $past(periph_out.clock_output))
    else $error("pin 4 not given to clock output");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > 6'h04
    |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid)
    else $error("write not answered");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
endmodule
bind gpio_port_with_pin_steering gpio_port_sva u_sva (.*);

//--- dv/gpio_port_with_pin_steering_bench.sv
`timescale 1ns/1ps
`include "gpio_port_consts.svh"
module gpio_port_with_pin_steering_bench;
  import gpio_port_pkg::*;
  ////////////////////////////////////////
  // Bench signals, named as the ports
  logic clk = 0;
  logic rstn = 0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, port_c_pin_in = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, port_b4_pin_in = 0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = '0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [5:0] ext = '0, v, port_a_pin_in, port_a_pin_out, port_a_pin_oe;
  periph_out_t periph_out = '0;
  periph_in_t periph_in;
  steer_out_t steer_out;
  logic [33:0] q[$];
  int err_count = 0;
  int n_compared = 0;
  gpio_port_with_pin_steering u_dut (.*);
  pin_partner u_pins (.pin_out(port_a_pin_out), .pin_oe(port_a_pin_oe), .ext_level(ext),
    .pin_level(port_a_pin_in));
  always #12.5 clk = ~clk;
  ////////////////////////////////////////
  // Compare and report
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Bus write, notes expected response
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic s, input logic [1:0] r);
    q.push_back({r, 32'h0000_0000});
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_wstrb <= {3'b000, s};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    repeat ($urandom % 3) @(posedge clk);
    s_axi_bready <= 1;
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 0;
  endtask
  // Bus read, notes expected answer
  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    q.push_back({r, 24'h00_0000, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    repeat ($urandom % 3) @(posedge clk);
    s_axi_rready <= 1;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 0;
  endtask
  // Answers taken off the queue as they arrive
  always @(posedge clk) begin
    if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0000_0000}, q.pop_front(), "bresp");
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, q.pop_front(), "read");
  end
  ////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(94642));
    repeat (12) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    rd(`OFS_DIRECTION, 8'h3F, `RESP_OKAY);
    rd(`OFS_LATCH, 8'h00, `RESP_OKAY);
    rd(`OFS_ANALOG_SEL, 8'h37, `RESP_OKAY);
    rd(`OFS_STEERING, 8'h00, `RESP_OKAY);
    ext <= 6'($urandom);
    port_c_pin_in <= 8'($urandom);
    $display("test reset_values done");
    repeat (4) @(posedge clk);
    rd(`OFS_PIN_DATA, {2'b00, ext & 6'h08}, `RESP_OKAY);
    wr(`OFS_ANALOG_SEL, 8'h00, 1'b1, `RESP_OKAY);
    rd(`OFS_PIN_DATA, {2'b00, ext}, `RESP_OKAY);
    wr(`OFS_PIN_DATA, 8'h00, 1'b0, `RESP_OKAY);
    rd(`OFS_LATCH, {2'b00, ext & 6'h37}, `RESP_OKAY);
    $display("test input_path done");
    for (int i = 0; i < 2; i++) begin
      v = 6'($urandom) & 6'h37;
      wr(i ? `OFS_LATCH : `OFS_PIN_DATA, {2'b00, v}, 1'b1, `RESP_OKAY);
      rd(`OFS_LATCH, {2'b00, v}, `RESP_OKAY);
    end
    ext <= ~v;
    wr(`OFS_DIRECTION, 8'h00, 1'b1, `RESP_OKAY);
    rd(`OFS_DIRECTION, 8'h08, `RESP_OKAY);
    repeat (4) @(posedge clk);
    rd(`OFS_PIN_DATA, {2'b00, v | 6'h08}, `RESP_OKAY);
    wr(`OFS_ANALOG_SEL, 8'h37, 1'b1, `RESP_OKAY);
    chk({22'h0, port_a_pin_oe, port_a_pin_out}, {22'h0, 6'h37, v}, "pins");
    rd(`OFS_PIN_DATA, 8'h08, `RESP_OKAY);
    $display("test output_path done");
    wr(`OFS_STEERING, 8'hFF, 1'b1, `RESP_OKAY);
    rd(`OFS_STEERING, 8'hF7, `RESP_OKAY);
    wr(`OFS_ANALOG_SEL, 8'h00, 1'b1, `RESP_OKAY);
    periph_out.guard_en <= 1;
    periph_out.conv1_guard_a <= 1;
    for (int s = 0; s < 2; s++) begin
      wr(`OFS_STEERING, {s[0], 1'b0, s[0], s[0], 3'b000, s[0]}, 1'b1, `RESP_OKAY);
      repeat (4) @(posedge clk);
      chk({24'h0, steer_out.port_c_oe, steer_out.port_c_val[5:4]},
        {24'h0, 8'h3C, s[0] ? 2'b10 : 2'b01}, "guard");
      chk({32'h0, periph_in.slave_select, periph_in.serial_data_in},
        {32'h0, s[0] ? port_c_pin_in[3] : ext[3], s[0] ? ext[3] : port_c_pin_in[1]},
        "ss_sd");
      chk({33'h0, periph_in.uart_receive_data}, {33'h0, s[0] ? v[4] : port_c_pin_in[5]}, "rx");
    end
    rd(`OFS_DIRECTION, 8'h08, `RESP_OKAY);
    wr(8'h40, 8'h55, 1'b1, `RESP_SLVERR);
    rd(8'h40, 8'h00, `RESP_SLVERR);
    $display("test steering done");
    periph_out.prog_data_oe <= 1;
    periph_out.prog_data <= ~v[0];
    periph_out.clock_output_en <= 1;
    periph_out.clock_output <= ~v[4];
    repeat (4) @(posedge clk);
    rd(`OFS_PIN_DATA, {2'b00, v ^ 6'h11 | 6'h08}, `RESP_OKAY);
    wr(`OFS_ANALOG_SEL, 8'h37, 1'b1, `RESP_OKAY);
    chk({22'h0, port_a_pin_oe, port_a_pin_out}, {22'h0, 6'h37, v ^ 6'h11}, "prio_pins");
    $display("test priority done");
    wrap_up();
  end
  // Watchdog against a hung handshake
  initial begin
    #50000;
    err_count++;
    wrap_up();
  end
endmodule

//--- dv/pin_partner.sv
`timescale 1ns/1ps
////////////////////////////////////////
// Outside world of the first port's pins
module pin_partner (
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe,
  input wire logic [5:0] ext_level,
  output logic [5:0] pin_level
);
  // Driven pins show the driver, released pins the outside level
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

//--- include/gpio_port_consts.svh
`ifndef GPIO_PORT_CONSTS_SVH
`define GPIO_PORT_CONSTS_SVH

// Register byte offsets
`define OFS_PIN_DATA 8'h00
`define OFS_DIRECTION 8'h04
`define OFS_LATCH 8'h08
`define OFS_ANALOG_SEL 8'h0C
`define OFS_STEERING 8'h10

// Reset values
`define RST_DIRECTION 6'h3F
`define RST_LATCH 6'h00
`define RST_ANALOG_SEL 6'h37
`define RST_STEERING 8'h00

// Implemented bits
`define ANALOG_SEL_MASK 6'h37
`define STEER_MASK_14 8'hF7
`define STEER_MASK_20 8'h33

// Input-only pin of the first port
`define INPUT_ONLY_BIT 3

// Steering field positions
`define STEER_RX_BIT 7
`define STEER_SDO_BIT 6
`define STEER_SS_BIT 5
`define STEER_SD_BIT 4
`define STEER_TX_BIT 2
`define STEER_GRDB_BIT 1
`define STEER_GRDA_BIT 0

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- include/gpio_port_pkg.sv
package gpio_port_pkg;

  // Output requests from on-chip peripherals
  typedef struct packed {
    logic prog_data;
    logic prog_data_oe;
    logic clock_output;
    logic clock_output_en;
    logic spi_sdo;
    logic spi_sdo_en;
    logic uart_dt_out;
    logic uart_dt_oe;
    logic uart_tx_out;
    logic uart_tx_oe;
    logic sda_out;
    logic sda_oe;
    logic conv1_guard_a;
    logic conv2_guard_a;
    logic conv1_guard_b;
    logic conv2_guard_b;
    logic guard_en;
  } periph_out_t;

  // Input levels steered back to peripherals
  typedef struct packed {
    logic uart_receive_data;
    logic slave_select;
    logic serial_data_in;
  } periph_in_t;

  // Overrides for the other ports' pins
  typedef struct packed {
    logic [7:0] port_c_oe;
    logic [7:0] port_c_val;
    logic port_b4_oe;
    logic port_b4_val;
  } steer_out_t;

  // Whole state of the port block
  typedef struct packed {
    logic [5:0] direction_reg;
    logic [5:0] output_latch_reg;
    logic [5:0] analog_select_reg;
    logic [7:0] alternate_pin_steering;
    logic [5:0] pa_sync1;
    logic [5:0] pa_sync2;
    logic [7:0] pc_sync1;
    logic [7:0] pc_sync2;
    logic pb4_sync1;
    logic pb4_sync2;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [7:0] w_data;
    logic w_strb0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [5:0] pin_out;
    logic [5:0] pin_oe;
    periph_in_t pin_to_periph;
    steer_out_t steer_out;
  } state_t;

endpackage
